/* File: rtl/redg_pkg.sv */
// constants for the rail enable gating and edge delay block
// assumes a single 25 MHz system clock and an 8-bit internal register port
`default_nettype none
package redg_pkg;

    // clock and time base
    localparam int unsigned REDG_CLK_HZ        = 25_000_000;
    localparam int unsigned REDG_MS_PER_S      = 1000;
    localparam int unsigned REDG_TICK_CYCLES_DEF = REDG_CLK_HZ / REDG_MS_PER_S;

    // register offsets
    localparam logic [7:0] REDG_OFS_RAIL1_DLY  = 8'h09;
    localparam logic [7:0] REDG_OFS_R2_MASK_A  = 8'h0a;
    localparam logic [7:0] REDG_OFS_R2_MASK_B  = 8'h0b;
    localparam logic [7:0] REDG_OFS_R2_DLY     = 8'h0c;

    // reset values
    localparam logic [7:0] REDG_RST_MASK_A     = 8'h00;
    localparam logic [7:0] REDG_RST_MASK_B     = 8'hc0;
    localparam logic [7:0] REDG_RST_DLY        = 8'h00;
    localparam logic [7:0] REDG_RD_UNMAPPED    = 8'h00;

    // field positions
    localparam int unsigned REDG_FALL_MSB      = 5;
    localparam int unsigned REDG_FALL_LSB      = 3;
    localparam int unsigned REDG_RISE_MSB      = 2;
    localparam int unsigned REDG_RISE_LSB      = 0;
    localparam int unsigned REDG_SEL_MSB       = 4;
    localparam int unsigned REDG_SEL_LSB       = 2;
    localparam int unsigned REDG_STEP_BIT      = 5;
    localparam int unsigned REDG_PGB_MSB       = 1;

    // source select codes
    localparam logic [2:0] REDG_SEL_CONTROL_INPUT_ONE       = 3'h0;
    localparam logic [2:0] REDG_SEL_CONTROL_INPUT_TWO       = 3'h1;
    localparam logic [2:0] REDG_SEL_CONTROL_INPUT_FIVE       = 3'h2;
    localparam logic [2:0] REDG_SEL_CONTROL_INPUT_FOUR       = 3'h3;
    localparam logic [2:0] REDG_SEL_CONTROL_INPUT_THREE       = 3'h4;
    localparam logic [2:0] REDG_SEL_CTL34      = 3'h5;
    localparam logic [2:0] REDG_SEL_CONTROL_INPUT_SIX       = 3'h6;
    localparam logic [2:0] REDG_SEL_ONE        = 3'h7;

    // control input indices
    localparam int unsigned REDG_CONTROL_INPUT_ONE = 0;
    localparam int unsigned REDG_CONTROL_INPUT_TWO = 1;
    localparam int unsigned REDG_CONTROL_INPUT_THREE = 2;
    localparam int unsigned REDG_CONTROL_INPUT_FOUR = 3;
    localparam int unsigned REDG_CONTROL_INPUT_FIVE = 4;
    localparam int unsigned REDG_CONTROL_INPUT_SIX = 5;

    // nominal edge delays in ms, real part may vary by ten percent
    localparam logic [6:0] REDG_DLY_MS_0 = 7'h00;
    localparam logic [6:0] REDG_DLY_MS_1 = 7'h02;
    localparam logic [6:0] REDG_DLY_MS_2 = 7'h04;
    localparam logic [6:0] REDG_DLY_MS_3 = 7'h08;
    localparam logic [6:0] REDG_DLY_MS_4 = 7'h10;
    localparam logic [6:0] REDG_DLY_MS_5 = 7'h18;
    localparam logic [6:0] REDG_DLY_MS_6 = 7'h20;
    localparam logic [6:0] REDG_DLY_MS_7 = 7'h40;

    typedef enum logic [0:0] {
        REDG_ST_IDLE   = 1'b0,
        REDG_ST_TIMING = 1'b1
    } redg_state_e;

    function automatic logic [6:0] redg_delay_ms(input logic [2:0] code);
        logic [6:0] ms;
        case (code)
            3'h0:    ms = REDG_DLY_MS_0;
            3'h1:    ms = REDG_DLY_MS_1;
            3'h2:    ms = REDG_DLY_MS_2;
            3'h3:    ms = REDG_DLY_MS_3;
            3'h4:    ms = REDG_DLY_MS_4;
            3'h5:    ms = REDG_DLY_MS_5;
            3'h6:    ms = REDG_DLY_MS_6;
            default: ms = REDG_DLY_MS_7;
        endcase
        return ms;
    endfunction

endpackage
`default_nettype wire

/* File: rtl/redg_edge_delay.sv */
// one rail enable edge delay: rising and falling delays in ms steps
// assumes raw_i is already synchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module redg_edge_delay
    import redg_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = REDG_TICK_CYCLES_DEF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       raw_i,
    input  wire logic [2:0] rise_code_i,
    input  wire logic [2:0] fall_code_i,
    output logic            en_o
);
    localparam int unsigned SUBW = $clog2(TICK_CYCLES + 1);

    redg_state_e      st_r;
    redg_state_e      st_nxt;
    logic             out_r;
    logic             out_nxt;
    logic             prev_r;
    logic [SUBW-1:0]  sub_r;
    logic [SUBW-1:0]  sub_nxt;
    logic [6:0]       ms_r;
    logic [6:0]       ms_nxt;
    logic [6:0]       target;

    always_comb begin
        target  = raw_i ? redg_delay_ms(rise_code_i)
                        : redg_delay_ms(fall_code_i);
        st_nxt  = st_r;
        out_nxt = out_r;
        sub_nxt = sub_r;
        ms_nxt  = ms_r;
        if (raw_i == out_r) begin
            st_nxt  = REDG_ST_IDLE;
            sub_nxt = '0;
            ms_nxt  = '0;
        end else if (raw_i != prev_r) begin
            // any change restarts the wait, short glitches pass only when the delay code is zero
            st_nxt  = REDG_ST_TIMING;
            sub_nxt = '0;
            ms_nxt  = '0;
            if (target == REDG_DLY_MS_0) begin
                out_nxt = raw_i;
            end
        end else begin
            case (st_r)
                REDG_ST_IDLE: begin
                    st_nxt = REDG_ST_TIMING;
                end
                REDG_ST_TIMING: begin
                    if (ms_r >= target) begin
                        out_nxt = raw_i;
                        st_nxt  = REDG_ST_IDLE;
                    end else if (sub_r == SUBW'(TICK_CYCLES - 1)) begin
                        sub_nxt = '0;
                        ms_nxt  = 7'(ms_r + 7'h01);
                    end else begin
                        sub_nxt = SUBW'(sub_r + 1'b1);
                    end
                end
                default: begin
                    st_nxt = REDG_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r   <= REDG_ST_IDLE;
            out_r  <= 1'b0;
            prev_r <= 1'b0;
            sub_r  <= '0;
            ms_r   <= '0;
        end else begin
            st_r   <= st_nxt;
            out_r  <= out_nxt;
            prev_r <= raw_i;
            sub_r  <= sub_nxt;
            ms_r   <= ms_nxt;
        end
    end

    assign en_o = out_r;

    AST_FOLLOWS_RAW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(out_r) |-> out_r == $past(raw_i))
        else $error("enable changed away from raw enable");
    AST_FALL_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(out_r) |-> $past(ms_r) >= redg_delay_ms($past(fall_code_i)))
        else $error("enable fell before its delay ran out");
    AST_RISE_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(out_r) |-> $past(ms_r) >= redg_delay_ms($past(rise_code_i)))
        else $error("enable rose before its delay ran out");
    AST_RISE_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (raw_i && !prev_r && !out_r && rise_code_i == 3'h0) |=> out_r)
        else $error("zero rise delay not immediate");
    AST_RESTART: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (raw_i != prev_r) |=> (ms_r == 7'h00 && sub_r == '0))
        else $error("raw change did not restart the count");
    COV_DELAYED_RISE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(out_r) && ms_r != 7'h00);
    COV_DELAYED_FALL: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(out_r) && ms_r != 7'h00);
endmodule
`default_nettype wire

/* File: rtl/redg_top.sv */
// enable gating for rail two: source mux and power-good masks,
// programmable edge delays for rails one and two and the 8-bit internal register port
// assumes pins are asynchronous and the register port is on SYS_CLK_I
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - rail two fall delay, bits 5:3, eight codes
// - rail two rise delay, bits 2:0, same codes
// - rail one fall delay held in bits 5:3
// - rail one rise delay held in bits 2:0
// - delays nominal, ten percent tolerance accepted
// - rail two source select routes one control input
// - code 101 needs inputs three and four
// - code 111 enables with constant one
// - mask bit zero includes, one excludes power-good
// - first mask register bit to rail map
// - second mask register: combined and switch b1
module redg_top
    import redg_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = REDG_TICK_CYCLES_DEF
) (
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [5:0] CTL_I,
    input  wire logic [7:0] PG_A_I,
    input  wire logic [1:0] PG_B_I,
    input  wire logic       RAIL1_RAW_EN_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WR_I,
    output logic      [7:0] REG_RD_DATA_O,
    output logic            RAIL2_STEP_O,
    output logic            RAIL1_EN_O,
    output logic            RAIL2_EN_O
);
    localparam int unsigned NPIN = 17;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] sync_r;
    logic [5:0]      ctl_s;
    logic [7:0]      pg_a_s;
    logic [1:0]      pg_b_s;
    logic            rail1_raw_s;

    logic [7:0]      mask_a_r;
    logic [7:0]      mask_a_nxt;
    logic [7:0]      mask_b_r;
    logic [7:0]      mask_b_nxt;
    logic [7:0]      dly2_r;
    logic [7:0]      dly2_nxt;
    logic [7:0]      dly1_r;
    logic [7:0]      dly1_nxt;
    logic [7:0]      rd_r;
    logic [7:0]      rd_nxt;

    logic [2:0]      sel;
    logic            src2;
    logic            pg_ok2;
    logic            raw2;

    // pin synchronisers, two flops per bit
    assign pin_raw = {RAIL1_RAW_EN_I, PG_B_I, PG_A_I, CTL_I};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge SYS_CLK_I) begin
                if (!RST_N_I) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= pin_raw[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign ctl_s       = sync_r[5:0];
    assign pg_a_s      = sync_r[13:6];
    assign pg_b_s      = sync_r[15:14];
    assign rail1_raw_s = sync_r[16];

    // register file
    always_comb begin
        mask_a_nxt = mask_a_r;
        mask_b_nxt = mask_b_r;
        dly2_nxt   = dly2_r;
        dly1_nxt   = dly1_r;
        rd_nxt     = REDG_RD_UNMAPPED;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                REDG_OFS_R2_MASK_A: mask_a_nxt = REG_WDATA_I;
                REDG_OFS_R2_MASK_B: mask_b_nxt = REG_WDATA_I;
                REDG_OFS_R2_DLY:    dly2_nxt   = REG_WDATA_I;
                REDG_OFS_RAIL1_DLY: dly1_nxt   = REG_WDATA_I;
                default: begin
                end
            endcase
        end
        case (REG_ADDR_I)
            REDG_OFS_R2_MASK_A: rd_nxt = mask_a_r;
            REDG_OFS_R2_MASK_B: rd_nxt = mask_b_r;
            REDG_OFS_R2_DLY:    rd_nxt = dly2_r;
            REDG_OFS_RAIL1_DLY: rd_nxt = dly1_r;
            default:            rd_nxt = REDG_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            mask_a_r <= REDG_RST_MASK_A;
            mask_b_r <= REDG_RST_MASK_B;
            dly2_r   <= REDG_RST_DLY;
            dly1_r   <= REDG_RST_DLY;
            rd_r     <= REDG_RD_UNMAPPED;
        end else begin
            mask_a_r <= mask_a_nxt;
            mask_b_r <= mask_b_nxt;
            dly2_r   <= dly2_nxt;
            dly1_r   <= dly1_nxt;
            rd_r     <= rd_nxt;
        end
    end

    assign REG_RD_DATA_O = rd_r;
    // step size is only driven out; the host owns when it changes
    assign RAIL2_STEP_O  = mask_b_r[REDG_STEP_BIT];

    // rail two enable source multiplexer
    assign sel = mask_b_r[REDG_SEL_MSB:REDG_SEL_LSB];

    always_comb begin
        case (sel)
            REDG_SEL_CONTROL_INPUT_ONE:  src2 = ctl_s[REDG_CONTROL_INPUT_ONE];
            REDG_SEL_CONTROL_INPUT_TWO:  src2 = ctl_s[REDG_CONTROL_INPUT_TWO];
            REDG_SEL_CONTROL_INPUT_FIVE:  src2 = ctl_s[REDG_CONTROL_INPUT_FIVE];
            REDG_SEL_CONTROL_INPUT_FOUR:  src2 = ctl_s[REDG_CONTROL_INPUT_FOUR];
            REDG_SEL_CONTROL_INPUT_THREE:  src2 = ctl_s[REDG_CONTROL_INPUT_THREE];
            REDG_SEL_CTL34: src2 = ctl_s[REDG_CONTROL_INPUT_THREE]
                                 & ctl_s[REDG_CONTROL_INPUT_FOUR];
            REDG_SEL_CONTROL_INPUT_SIX:  src2 = ctl_s[REDG_CONTROL_INPUT_SIX];
            REDG_SEL_ONE:   src2 = 1'b1;
            default:        src2 = 1'b0;
        endcase
    end

    // a set mask bit forces that power-good to count as good
    assign pg_ok2 = (&(pg_a_s | mask_a_r))
                  & (&(pg_b_s | mask_b_r[REDG_PGB_MSB:0]));
    assign raw2   = src2 & pg_ok2;

    redg_edge_delay #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_rail2 (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (RST_N_I),
        .raw_i       (raw2),
        .rise_code_i (dly2_r[REDG_RISE_MSB:REDG_RISE_LSB]),
        .fall_code_i (dly2_r[REDG_FALL_MSB:REDG_FALL_LSB]),
        .en_o        (RAIL2_EN_O)
    );

    redg_edge_delay #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_rail1 (
        .clk_i       (SYS_CLK_I),
        .rst_n_i     (RST_N_I),
        .raw_i       (rail1_raw_s),
        .rise_code_i (dly1_r[REDG_RISE_MSB:REDG_RISE_LSB]),
        .fall_code_i (dly1_r[REDG_FALL_MSB:REDG_FALL_LSB]),
        .en_o        (RAIL1_EN_O)
    );

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    AST_SEL_ONE: assert property (
        (sel == REDG_SEL_ONE && mask_a_r == 8'hff && (&mask_b_r[1:0]))
        |-> raw2)
        else $error("constant-one source did not enable");
    AST_SEL_AND: assert property (
        (sel == REDG_SEL_CTL34 && raw2)
        |-> (ctl_s[REDG_CONTROL_INPUT_THREE] && ctl_s[REDG_CONTROL_INPUT_FOUR]))
        else $error("and source enabled without both inputs");
    AST_SEL_ROUTE5: assert property (
        (sel == REDG_SEL_CONTROL_INPUT_FIVE && raw2) |-> ctl_s[REDG_CONTROL_INPUT_FIVE])
        else $error("select 010 did not route input five");
    AST_PG_GATE: assert property (
        raw2 |-> ((pg_a_s | mask_a_r) == 8'hff))
        else $error("unmasked power-good low yet enabled");
    AST_MASKA_WR: assert property (
        (REG_WR_I && REG_ADDR_I == REDG_OFS_R2_MASK_A)
        |=> ##1 REG_RD_DATA_O == $past(REG_WDATA_I, 2)
            || $past(REG_ADDR_I) != REDG_OFS_R2_MASK_A)
        else $error("mask register readback wrong");
    AST_PGB_GATE: assert property (
        (raw2) |-> ((pg_b_s | mask_b_r[1:0]) == 2'h3))
        else $error("second mask group not honoured");
    AST_RAIL1_FIELD: assert property (
        (REG_WR_I && REG_ADDR_I == REDG_OFS_RAIL1_DLY)
        |=> dly1_r[REDG_FALL_MSB:REDG_FALL_LSB] == $past(REG_WDATA_I[5:3]))
        else $error("rail one fall field not stored");
    AST_RAIL1_ZERO: assert property (
        ($rose(rail1_raw_s) && dly1_r[2:0] == 3'h0 && !RAIL1_EN_O)
        |=> RAIL1_EN_O)
        else $error("rail one zero rise delay not immediate");

    AST_ROUTE1: assert property (
        (sel == REDG_SEL_CONTROL_INPUT_ONE && raw2) |-> ctl_s[REDG_CONTROL_INPUT_ONE])
        else $error("select 000 did not route input one");
    AST_ROUTE6: assert property (
        (sel == REDG_SEL_CONTROL_INPUT_SIX && raw2) |-> ctl_s[REDG_CONTROL_INPUT_SIX])
        else $error("select 110 did not route input six");
    AST_PGA_RAIL1: assert property (
        (!pg_a_s[0] && !mask_a_r[0]) |-> !raw2)
        else $error("unmasked rail one power-good ignored");
    AST_PGB_LOAD_SWITCH_B1: assert property (
        (!pg_b_s[0] && !mask_b_r[0]) |-> !raw2)
        else $error("unmasked switch b1 power-good ignored");

    COV_R2_EN: cover property ($rose(RAIL2_EN_O));
    COV_R2_AND: cover property (sel == REDG_SEL_CTL34 && $rose(RAIL2_EN_O));
    COV_R1_FALL: cover property ($fell(RAIL1_EN_O));
endmodule
`default_nettype wire

/* File: tb/redg_pin_model.sv */
// model of the far side: control pins, power-goods and rail one raw enable
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module redg_pin_model (
    output var logic [5:0] ctl_o,
    output var logic [7:0] pg_a_o,
    output var logic [1:0] pg_b_o,
    output var logic       raw1_o
);
    initial begin
        ctl_o = 6'h00;
        pg_a_o = 8'hff;
        pg_b_o = 2'h3;
        raw1_o = 1'b0;
    end
    task automatic set_ctl(input logic [5:0] v);
        ctl_o = v;
    endtask
    // all ten power-goods, b pair in the upper two bits
    task automatic set_pg(input logic [9:0] v);
        {pg_b_o, pg_a_o} = v;
    endtask
    task automatic set_raw1(input logic v);
        raw1_o = v;
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the rail enable gating block
// assumes a tick of 4 cycles per ms so long delays stay short
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import redg_pkg::*;
    localparam int T = 4;
    logic       clk;
    logic       rst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] rdata;
    logic       step;
    wire  [1:0] ens;
    logic [5:0] ctl;
    logic [7:0] pg_a;
    logic [1:0] pg_b;
    logic       raw1;
    int         mismatches = 0;
    int         n_checks = 0;
    int         ms_tab[8] = '{0, 2, 4, 8, 16, 24, 32, 64};

    redg_pin_model pm (.ctl_o(ctl), .pg_a_o(pg_a), .pg_b_o(pg_b),
                       .raw1_o(raw1));
    redg_top #(.TICK_CYCLES(T)) dut (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .CTL_I(ctl), .PG_A_I(pg_a),
        .PG_B_I(pg_b), .RAIL1_RAW_EN_I(raw1), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_DATA_O(rdata),
        .RAIL2_STEP_O(step), .RAIL1_EN_O(ens[0]), .RAIL2_EN_O(ens[1]));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_rst(input logic v);
        rst_n = v;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        // an idle edge keeps the next write from re-raising wr at once
        cyc(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        cyc(1);
        check(rdata, exp);
    endtask

    function automatic logic src_exp(input logic [2:0] c,
                                     input logic [5:0] p);
        case (c)
            3'h0: return p[0];
            3'h1: return p[1];
            3'h2: return p[4];
            3'h3: return p[3];
            3'h4: return p[2];
            3'h5: return p[2] & p[3];
            3'h6: return p[5];
            default: return 1'b1;
        endcase
    endfunction

    // reset values and outputs after reset
    task automatic reset_vals();
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h0a, 8'h00);
        rd_chk(8'h0b, 8'hc0);
        rd_chk(8'h0c, 8'h00);
        check({step, ens}, 3'h0);
    endtask

    // read back, unmapped refusal, step bit, reset in mid-run
    task automatic t_regs();
        logic [7:0] a;
        for (int i = 9; i < 14; i++) begin
            a = 8'(i);
            wr_reg(a, 8'ha5 ^ a);
        end
        for (int i = 9; i < 13; i++) begin
            a = 8'(i);
            rd_chk(a, 8'ha5 ^ a);
        end
        rd_chk(8'h0d, 8'h00);
        check(step, 1'b1);
        set_rst(1'b0);
        cyc(2);
        set_rst(1'b1);
        reset_vals();
    endtask

    // every select code against a set of pin patterns
    task automatic t_select();
        logic [5:0] p;
        wr_reg(8'h0a, 8'hff);
        for (int c = 0; c < 8; c++) begin
            wr_reg(8'h0b, {3'b000, 3'(c), 2'b11});
            for (int j = 0; j < 8; j++) begin
                p = (j < 6) ? 6'(1 << j) : ((j == 6) ? 6'h0c : 6'h00);
                pm.set_ctl(p);
                cyc(6);
                check(ens[1], src_exp(3'(c), p));
            end
        end
        pm.set_ctl(6'h00);
    endtask

    // each power-good included while masked off, excluded when masked
    task automatic t_mask();
        wr_reg(8'h0b, 8'h1c);
        for (int i = 0; i < 10; i++) begin
            wr_reg(8'h0a, 8'h00);
            pm.set_pg(~(10'h001 << i));
            cyc(6);
            check(ens[1], 1'b0);
            wr_reg(8'h0a, (i < 8) ? 8'(1 << i) : 8'h00);
            wr_reg(8'h0b, 8'h1c | ((i >= 8) ? 8'(1 << (i - 8)) : 8'h00));
            cyc(6);
            check(ens[1], 1'b1);
            wr_reg(8'h0b, 8'h1c);
        end
        pm.set_pg(10'h3ff);
    endtask

    // drive one rail's raw enable and time the output edge
    task automatic meas(input int r, input logic lvl, input logic [2:0] c);
        int n;
        int nom;
        int tol;
        nom = ms_tab[c] * T + 3;
        tol = ms_tab[c] * T / 10 + 2;
        n = 0;
        if (r == 0)
            pm.set_raw1(lvl);
        else
            pm.set_ctl({5'b0, lvl});
        while (ens[r] !== lvl && n < 400) begin
            cyc(1);
            n++;
        end
        check((n >= nom - tol && n <= nom + tol) ? nom : n, nom);
    endtask

    // rise code k and fall code 7-k, so a swapped field shows
    task automatic t_delays(input int r);
        if (r == 1) begin
            wr_reg(8'h0a, 8'hff);
            wr_reg(8'h0b, 8'h03);
        end
        for (int k = 0; k < 8; k++) begin
            wr_reg((r == 0) ? 8'h09 : 8'h0c, {2'b00, 3'(7 - k), 3'(k)});
            meas(r, 1'b1, 3'(k));
            meas(r, 1'b0, 3'(7 - k));
        end
    endtask

    // short pulses filtered, count restarts on each change
    task automatic t_glitch();
        wr_reg(8'h0c, 8'h01);
        pm.set_ctl(6'h01);
        cyc(5);
        pm.set_ctl(6'h00);
        cyc(20);
        check(ens[1], 1'b0);
        pm.set_ctl(6'h01);
        cyc(6);
        pm.set_ctl(6'h00);
        cyc(1);
        meas(1, 1'b1, 3'h1);
    endtask

    initial begin
        #(30000 * 40);
        mismatches++;
        complete_run();
    end

    initial begin
        set_rst(1'b0);
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        cyc(5);
        set_rst(1'b1);
        reset_vals();
        t_regs();
        t_select();
        t_mask();
        t_delays(0);
        t_delays(1);
        t_glitch();
        complete_run();
    end
endmodule
`default_nettype wire
